//--- hcc_arg_array.sv
// Word-wide argument array with per-byte write lanes and two read ports
`timescale 1ns/10ps
module hcc_arg_array
  import hcc_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int IDXW  = 6
) (
  input  wire logic            mclk,
  input  wire logic            wrEn,    // One-cycle write command
  input  wire logic [3:0]      wrStrb,  // Byte lanes to update
  input  wire logic [IDXW-1:0] wrIdx,   // Word index of the write
  input  wire logic [31:0]     wrData,  // Write word
  input  wire logic [IDXW-1:0] busIdx,  // Bus read index
  output logic      [31:0]     busData, // Bus read word, combinational
  input  wire logic [IDXW-1:0] coreIdx, // Core read index
  output logic      [31:0]     coreData // Core read word, registered
);
  logic [31:0] memReg [DEPTH]; // Flip-flop storage, no reset to save area
  wire  [31:0] mergedWord;     // Old word with the strobed lanes replaced

  ////////////////////////////////////////////////////////////////////////
  // Each byte lane picks new or old data, so byte writes keep neighbours
  for (genvar b = 0; b < 4; b++) begin : gLane
    assign mergedWord[8*b +: 8] = wrStrb[b] ? wrData[8*b +: 8]
                                            : memReg[wrIdx][8*b +: 8];
  end

  // A single process writes the store, so it has one driver only
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      memReg[wrIdx] <= mergedWord;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Whole-word reads for the bus and for the core
  assign busData = memReg[busIdx];

  // Core side sees a registered word, one cycle after the index
  always_ff @(posedge mclk) begin
    coreData <= memReg[coreIdx];
  end
endmodule

//--- hcc_control_slave.sv
// APB control and status slave of an accelerator core, with argument ports
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps
module hcc_control_slave
  import hcc_pkg::*;
#(
  parameter bit CHAIN_MODE = 1'b0, // Chained control mode
  parameter int NUM_IN     = 2,    // Scalar input arguments
  parameter int NUM_OUT    = 2,    // Scalar output arguments
  parameter int ARR_DEPTH  = 64,   // Array words in the window
  parameter int ARR_IDXW   = 6     // Index width of the array
) (
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     coreGo,
  input  wire logic                coreFinished,
  input  wire logic                coreQuiet,
  input  wire logic                coreAcceptsInput,
  output logic                     coreProceed,
  output logic [NUM_IN*32-1:0]     argIn,
  output logic [NUM_IN-1:0]        argumentValidStrobe,
  input  wire logic [NUM_OUT*32-1:0] argOut,
  output logic [NUM_OUT-1:0]       argumentAcknowledgeStrobe,
  input  wire logic [ARR_IDXW-1:0] coreArrIdx,
  output logic      [31:0]         coreArrData,
  output logic                     irq
);
  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (NUM_IN < 1 || NUM_IN > 8 || NUM_OUT < 1 || NUM_OUT > 8) begin : gBadArgs
    $error("Argument counts must lie between 1 and 8");
  end
  if (ARR_DEPTH < 1 || ARR_DEPTH > 64 || (1 << ARR_IDXW) < ARR_DEPTH) begin : gBadArr
    $error("Array depth must fit the 256-byte window and the index");
  end

  ////////////////////////////////////////////////////////////////////////
  // State
  logic [31:0]         prdataReg;      // Read data held for the master
  logic                preadyReg;      // Access answer
  logic                pslverrReg;     // Error answer, unmapped access or read-only write
  logic                goReg;          // Start handshake toward the core
  logic                proceedReg;     // Continue pulse toward the core
  logic                restartReg;     // Auto restart enable
  logic                proceedSeenReg; // Proceed met finished, chain mode
  logic                gieReg;         // Global interrupt enable
  logic [1:0]          ienReg;         // Per-source enables
  logic [1:0]          istatReg;       // Sticky source status
  logic [1:0]          srcPrevReg;     // Previous source levels
  logic                irqReg;         // Interrupt output
  logic [NUM_IN*32-1:0] argInReg;      // Scalar input words
  logic [NUM_IN-1:0]   validReg;       // Valid strobes
  logic [NUM_OUT-1:0]  ackReg;         // Acknowledge strobes

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  // The answer comes one cycle into the access phase; the write lands
  // on the edge where the master sees pready, never earlier.
  wire        accessPh  = psel && penable && !preadyReg;
  wire        commit    = psel && penable && preadyReg;
  wire        wrCommit  = commit && pwrite && !pslverrReg;
  wire [9:0]  wordIdx   = paddr[11:2];
  wire        isCtrl    = paddr == HCC_CTRL_OFS;
  wire        isGie     = paddr == HCC_GIE_OFS;
  wire        isIen     = paddr == HCC_IEN_OFS;
  wire        isIdis    = paddr == HCC_IDIS_OFS;
  wire        isIstat   = paddr == HCC_ISTAT_OFS;
  wire        isValid   = paddr == HCC_VALID_OFS;
  wire        isAck     = paddr == HCC_ACK_OFS;
  wire [9:0]  inIdx     = wordIdx - HCC_ARGIN_OFS[11:2];
  wire [9:0]  outIdx    = wordIdx - HCC_ARGOUT_OFS[11:2];
  wire        isArgIn   = paddr[1:0] == 2'h0 && paddr >= HCC_ARGIN_OFS
                          && inIdx < 10'(NUM_IN);
  wire        isArgOut  = paddr[1:0] == 2'h0 && paddr >= HCC_ARGOUT_OFS
                          && outIdx < 10'(NUM_OUT);
  wire [ARR_IDXW-1:0] arrIdx = ARR_IDXW'(paddr[7:2]);
  wire        isArr     = paddr[HCC_WIN_MSB:HCC_WIN_LSB] == HCC_WIN_TAG
                          && paddr[1:0] == 2'h0 && {1'b0, paddr[7:2]} < 7'(ARR_DEPTH);
  wire        isRo      = isArgOut;
  wire        mapped    = isCtrl || isGie || isIen || isIdis || isIstat
                          || isValid || isAck || isArgIn || isArgOut || isArr;
  // Read-only words refuse writes with an error, nothing changes
  wire        badAccess = !mapped || (pwrite && isRo);
  wire        arrWr     = wrCommit && isArr;

  ////////////////////////////////////////////////////////////////////////
  // Argument array
  logic [31:0] arrBusData; // Array word at the bus index

  hcc_arg_array #(
    .DEPTH (ARR_DEPTH),
    .IDXW  (ARR_IDXW)
  ) uArray (
    .mclk     (mclk),
    .wrEn     (arrWr),
    .wrStrb   (pstrb),
    .wrIdx    (arrIdx),
    .wrData   (pwdata),
    .busIdx   (arrIdx),
    .busData  (arrBusData),
    .coreIdx  (coreArrIdx),
    .coreData (coreArrData)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer
  wire [31:0] ctrlWord = {24'h00_0000, restartReg, 2'h0, proceedReg,
                          coreAcceptsInput, coreQuiet, coreFinished, goReg};
  wire [31:0] argInSel  = argInReg[32*inIdx[2:0] +: 32];
  wire [31:0] argOutSel = argOut[32*outIdx[2:0] +: 32];
  logic [31:0] readMux; // Word returned for the addressed register

  always_comb begin
    readMux = HCC_WORD_RST;
    if (isCtrl) begin
      readMux = ctrlWord;
    end else if (isGie) begin
      readMux = {31'h0000_0000, gieReg};
    end else if (isIen || isIdis) begin
      readMux = {30'h0000_0000, ienReg};
    end else if (isIstat) begin
      readMux = {30'h0000_0000, istatReg};
    end else if (isValid) begin
      readMux = 32'(validReg);
    end else if (isAck) begin
      readMux = 32'(ackReg);
    end else if (isArgIn) begin
      readMux = argInSel;
    end else if (isArgOut) begin
      readMux = argOutSel;
    end else if (isArr) begin
      readMux = arrBusData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer: pready one cycle into access, for one cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      preadyReg  <= 1'b0;
      pslverrReg <= 1'b0;
      prdataReg  <= HCC_WORD_RST;
    end else begin
      preadyReg  <= accessPh;
      pslverrReg <= accessPh && badAccess;
      if (accessPh && !pwrite) begin
        prdataReg <= readMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core handshake
  wire ctrlWr      = wrCommit && isCtrl;
  wire swStart     = ctrlWr && pwdata[HCC_GO_BIT];
  wire swProceed   = ctrlWr && pwdata[HCC_PROCEED_BIT];
  // Chain mode waits for accept after a proceed seen with finished
  wire chainFire   = restartReg && coreAcceptsInput
                     && (proceedSeenReg || (proceedReg && coreFinished));
  wire plainFire   = restartReg && coreFinished;
  wire autoFire    = CHAIN_MODE ? chainFire : plainFire;
  // Go holds until the core takes its inputs, then drops unless restarting
  wire goNext      = swStart || autoFire || (goReg && !coreAcceptsInput);

  always_ff @(posedge mclk) begin
    if (reset) begin
      goReg          <= 1'b0;
      proceedReg     <= 1'b0;
      restartReg     <= 1'b0;
      proceedSeenReg <= 1'b0;
    end else begin
      goReg      <= goNext;
      proceedReg <= swProceed;
      if (ctrlWr) begin
        restartReg <= pwdata[HCC_RESTART_BIT];
      end
      // Remember proceed met finished until the restart consumes it
      if (proceedReg && coreFinished) begin
        proceedSeenReg <= 1'b1;
      end else if (chainFire) begin
        proceedSeenReg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scalar arguments and their strobes
  for (genvar i = 0; i < NUM_IN; i++) begin : gArgIn
    wire hit = wrCommit && isArgIn && inIdx == 10'(i);
    always_ff @(posedge mclk) begin
      if (reset) begin
        argInReg[32*i +: 32] <= HCC_WORD_RST;
      end else if (hit) begin
        argInReg[32*i +: 32] <= pwdata;
      end
    end
  end

  // Strobes last one cycle per written one bit
  always_ff @(posedge mclk) begin
    if (reset) begin
      validReg <= '0;
      ackReg   <= '0;
    end else begin
      validReg <= (wrCommit && isValid) ? pwdata[NUM_IN-1:0] : '0;
      ackReg   <= (wrCommit && isAck) ? pwdata[NUM_OUT-1:0] : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt sources, enables and sticky status
  wire [1:0] srcLevel = {coreAcceptsInput, coreFinished};
  // Rising edges only, so a long finished level counts once
  wire [1:0] srcEvent = srcLevel & ~srcPrevReg;
  wire [1:0] ienSet   = (wrCommit && isIen) ? pwdata[1:0] : 2'h0;
  wire [1:0] ienClr   = (wrCommit && isIdis) ? pwdata[1:0] : 2'h0;
  wire [1:0] stToggle = (wrCommit && isIstat) ? pwdata[1:0] : 2'h0;
  // A new event beats a toggle in the same cycle, so none is lost
  wire [1:0] istatNext = srcEvent | (istatReg ^ stToggle);
  wire [1:0] ienNext   = ienSet | (ienReg & ~ienClr);
  wire       irqNext   = gieReg && |(istatReg & ienReg);

  always_ff @(posedge mclk) begin
    if (reset) begin
      gieReg     <= 1'b0;
      ienReg     <= HCC_SRC_RST;
      istatReg   <= HCC_SRC_RST;
      srcPrevReg <= HCC_SRC_RST;
      irqReg     <= 1'b0;
    end else begin
      if (wrCommit && isGie) begin
        gieReg <= pwdata[0];
      end
      ienReg     <= ienNext;
      istatReg   <= istatNext;
      srcPrevReg <= srcLevel;
      irqReg     <= irqNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops
  assign prdata                    = prdataReg;
  assign pready                    = preadyReg;
  assign pslverr                   = pslverrReg;
  assign coreGo                    = goReg;
  assign coreProceed               = proceedReg;
  assign argIn                     = argInReg;
  assign argumentValidStrobe       = validReg;
  assign argumentAcknowledgeStrobe = ackReg;
  assign irq                       = irqReg;
endmodule

//--- hcc_control_slave_tb.sv
// Self-checking bench of the core control slave driven over APB
`timescale 1ns/10ps
module hcc_control_slave_tb
  import hcc_pkg::*;
  ;
  logic        mclk = 1'b0;       // 20 MHz clock
  logic        reset = 1'b1;      // Synchronous, active high
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        coreFinished = 1'b0, coreQuiet = 1'b0, coreAcceptsInput = 1'b0;
  logic [63:0] argOut = 64'h0;    // Core outputs, bench driven
  logic [5:0]  coreArrIdx = 6'h00;
  logic [31:0] prdata, coreArrData, rdv, expv, seed = 32'h0000_fbbb;
  logic [63:0] argIn;
  logic [1:0]  argumentValidStrobe, argumentAcknowledgeStrobe;
  logic        pready, pslverr, coreGo, coreProceed, irq, rerr;
  int          bad_count = 0, checks = 0, n;
  int          cnt[5] = '{default: 0}; // High cycles seen per strobe
  int          base[5];                // Snapshot before a test

  hcc_control_slave uut (
    .mclk(mclk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coreGo(coreGo), .coreFinished(coreFinished), .coreQuiet(coreQuiet),
    .coreAcceptsInput(coreAcceptsInput), .coreProceed(coreProceed), .argIn(argIn),
    .argumentValidStrobe(argumentValidStrobe), .argOut(argOut),
    .argumentAcknowledgeStrobe(argumentAcknowledgeStrobe), .coreArrIdx(coreArrIdx),
    .coreArrData(coreArrData), .irq(irq));

  always #25 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////////
  // One-cycle pulses are tallied, so no fixed latency is assumed
  always @(negedge mclk) begin
    cnt[0] += argumentValidStrobe[0];
    cnt[1] += argumentValidStrobe[1];
    cnt[2] += argumentAcknowledgeStrobe[0];
    cnt[3] += argumentAcknowledgeStrobe[1];
    cnt[4] += coreProceed;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Word after a write that touches only the strobed byte lanes
  function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = d[8*i +: 8];
    return o;
  endfunction
  task automatic chkWord(input string what, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chkBit(input string what, input logic e, g);
    chkWord(what, {31'h0, e}, {31'h0, g});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      bad_count++;
      conclude();
    end
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 4'hf);
  endtask
  // One-cycle pulse of finished (1) or accepts input (0)
  task automatic pulse(input logic fin);
    @(posedge mclk);
    coreFinished <= fin;
    coreAcceptsInput <= !fin;
    @(posedge mclk);
    coreFinished <= 1'b0;
    coreAcceptsInput <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(negedge mclk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chkBit("coreGo", 1'b0, coreGo);
    chkBit("irq", 1'b0, irq);
    chkWord("argIn", 32'h0, argIn[31:0]);
    rd(HCC_IEN_OFS);
    chkWord("enables", 32'h0, rdv);
    $display("test reset done");
    // Random core levels and scalar words
    for (n = 0; n < 8; n++) begin
      seed = xs(seed);
      @(posedge mclk);
      coreQuiet <= seed[0];
      coreFinished <= seed[1];
      coreAcceptsInput <= seed[2];
      argOut <= {seed, ~seed};
      rd(HCC_CTRL_OFS);
      chkWord("levels", {28'h0, seed[2], seed[0], seed[1], 1'b0}, rdv & 32'hf);
      rd(HCC_ARGOUT_OFS + 12'h004);
      chkWord("argOut", seed, rdv);
      expv = xs(seed);
      wr(HCC_ARGIN_OFS + (n[0] ? 12'h004 : 12'h000), expv);
      rd(HCC_ARGIN_OFS + (n[0] ? 12'h004 : 12'h000));
      chkWord("argIn read", expv, rdv);
      chkWord("argIn port", expv, n[0] ? argIn[63:32] : argIn[31:0]);
    end
    coreQuiet <= 1'b0;
    coreFinished <= 1'b0;
    coreAcceptsInput <= 1'b0;
    wr(12'h01c, 32'hffff_ffff);
    chkBit("unmapped err", 1'b1, rerr);
    wr(HCC_ARGOUT_OFS, 32'h1234_5678);
    chkBit("argOut err", 1'b1, rerr);
    $display("test scalars done");
    wr(HCC_CTRL_OFS, 32'h1);
    settle;
    chkBit("go on start", 1'b1, coreGo);
    pulse(1'b0);
    settle;
    chkBit("go after accept", 1'b0, coreGo);
    base = cnt;
    wr(HCC_CTRL_OFS, 32'h10);
    settle;
    chkWord("proceed pulses", 32'h1, 32'(cnt[4] - base[4]));
    wr(HCC_CTRL_OFS, 32'h80);
    rd(HCC_CTRL_OFS);
    chkBit("restart bit", 1'b1, rdv[HCC_RESTART_BIT]);
    pulse(1'b1);
    settle;
    chkBit("go on restart", 1'b1, coreGo);
    pulse(1'b0);
    wr(HCC_CTRL_OFS, 32'h0);
    pulse(1'b1);
    settle;
    chkBit("go restart off", 1'b0, coreGo);
    $display("test start done");
    for (n = 1; n < 4; n++) begin
      base = cnt;
      wr(HCC_VALID_OFS, 32'(n));
      wr(HCC_ACK_OFS, 32'(n));
      settle;
      chkWord("valid0", 32'(n % 2), 32'(cnt[0] - base[0]));
      chkWord("valid1", 32'(n / 2), 32'(cnt[1] - base[1]));
      chkWord("ack0", 32'(n % 2), 32'(cnt[2] - base[2]));
      chkWord("ack1", 32'(n / 2), 32'(cnt[3] - base[3]));
    end
    $display("test strobes done");
    seed = xs(seed);
    wr(12'h1fc, seed);
    wr(12'h100, ~seed);
    rd(12'h1fc);
    chkWord("array word", seed, rdv);
    apb(1'b1, 12'h1fc, 32'haabb_ccdd, 4'b0010);
    expv = merge(seed, 32'haabb_ccdd, 4'b0010);
    rd(12'h1fc);
    chkWord("array byte", expv, rdv);
    coreArrIdx <= 6'h3f;
    settle;
    chkWord("core array", expv, coreArrData);
    $display("test array done");
    rd(HCC_ISTAT_OFS);
    wr(HCC_ISTAT_OFS, rdv);
    rd(HCC_ISTAT_OFS);
    chkWord("status cleared", 32'h0, rdv);
    pulse(1'b0);
    rd(HCC_ISTAT_OFS);
    chkWord("status accepts", 32'h2, rdv);
    wr(HCC_ISTAT_OFS, 32'h2);
    wr(HCC_IEN_OFS, 32'h1);
    wr(HCC_GIE_OFS, 32'h1);
    pulse(1'b1);
    settle;
    chkBit("irq finished", 1'b1, irq);
    wr(HCC_IDIS_OFS, 32'h1);
    settle;
    chkBit("irq disabled", 1'b0, irq);
    rd(HCC_ISTAT_OFS);
    chkWord("status sticky", 32'h1, rdv);
    wr(HCC_IEN_OFS, 32'h2);
    rd(HCC_IDIS_OFS);
    chkWord("enables", 32'h2, rdv);
    wr(HCC_ISTAT_OFS, 32'h2);
    settle;
    chkBit("irq toggled", 1'b1, irq);
    wr(HCC_GIE_OFS, 32'h0);
    settle;
    chkBit("irq global off", 1'b0, irq);
    wr(HCC_ISTAT_OFS, 32'h3);
    rd(HCC_ISTAT_OFS);
    chkWord("status clear", 32'h0, rdv);
    $display("test interrupts done");
    conclude();
  end
endmodule

//--- hcc_monitor.sv
// Port-level checker of the core control slave, bound to its top module
`timescale 1ns/10ps
module hcc_monitor
  import hcc_pkg::*;
#(
  parameter int NUM_IN = 2 // Scalar inputs, as in the design
) (
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic [11:0]       paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              coreGo,
  input wire logic              coreFinished,
  input wire logic              coreQuiet,
  input wire logic              coreAcceptsInput,
  input wire logic [NUM_IN-1:0] argumentValidStrobe,
  input wire logic              irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire  wrDone   = psel && penable && pready && pwrite;           // A write lands
  wire  validHit = wrDone && paddr == HCC_VALID_OFS && pwdata[0]; // Valid 0 asked
  logic gieOn;  // Shadow of the global enable
  logic autoOn; // Shadow of auto restart
  logic ienOn;  // Shadow of source 0 enable
  //////////////////////////////////////////////////////////////////////////////
  // Shadows follow landed writes, so a broken readback cannot hide a fault
  always_ff @(posedge mclk) begin
    if (reset) begin
      gieOn <= 1'b0;
      autoOn <= 1'b0;
      ienOn <= 1'b0;
    end else if (wrDone) begin
      if (paddr == HCC_GIE_OFS) gieOn <= pwdata[0];
      if (paddr == HCC_CTRL_OFS) autoOn <= pwdata[HCC_RESTART_BIT];
      if (paddr == HCC_IEN_OFS && pwdata[0]) ienOn <= 1'b1;
      if (paddr == HCC_IDIS_OFS && pwdata[0]) ienOn <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  a_go_after_start: assert property (
    wrDone && paddr == HCC_CTRL_OFS && pwdata[HCC_GO_BIT] |-> ##[1:2] coreGo)
    else $error("core go not raised after start write");
  a_go_holds: assert property (coreGo && !coreAcceptsInput |=> coreGo)
    else $error("core go dropped before input accepted");
  a_restart_done: assert property (autoOn && coreFinished |-> ##[1:2] coreGo)
    else $error("no restart after finished");
  a_bus_answer: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered next cycle");
  a_valid_cause: assert property (
    argumentValidStrobe[0] |-> $past(validHit) || $past(validHit, 2))
    else $error("valid strobe without a write");
  a_irq_gated: assert property (
    !gieOn && !$past(gieOn) && !$past(gieOn, 2) |-> !irq)
    else $error("irq while global enable off");
  a_irq_on_done: assert property ($rose(coreFinished) && gieOn && ienOn |-> ##[1:3] irq)
    else $error("irq missing after finished");
  a_quiet_read: assert property (
    psel && penable && pready && !pwrite && paddr == HCC_CTRL_OFS
    |-> prdata[HCC_QUIET_BIT] == $past(coreQuiet))
    else $error("quiet bit read wrong");
endmodule
bind hcc_control_slave hcc_monitor #(.NUM_IN(NUM_IN)) mon (
  .mclk(mclk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .coreGo(coreGo),
  .coreFinished(coreFinished), .coreQuiet(coreQuiet), .coreAcceptsInput(coreAcceptsInput),
  .argumentValidStrobe(argumentValidStrobe), .irq(irq));

//--- hcc_pkg.sv
// Register map, field positions and reset values of the core control slave
package hcc_pkg;
  // Byte offsets of the register words
  localparam logic [11:0] HCC_CTRL_OFS    = 12'h000; // Start, status, restart, proceed
  localparam logic [11:0] HCC_GIE_OFS     = 12'h004; // Global interrupt output enable
  localparam logic [11:0] HCC_IEN_OFS     = 12'h008; // Enable mask, reads back enables
  localparam logic [11:0] HCC_IDIS_OFS    = 12'h00c; // Disable mask, reads back enables
  localparam logic [11:0] HCC_ISTAT_OFS   = 12'h010; // Status, write one toggles
  localparam logic [11:0] HCC_VALID_OFS   = 12'h014; // Argument valid strobes
  localparam logic [11:0] HCC_ACK_OFS     = 12'h018; // Argument acknowledge strobes
  localparam logic [11:0] HCC_ARGIN_OFS   = 12'h020; // Scalar inputs, one word each
  localparam logic [11:0] HCC_ARGOUT_OFS  = 12'h040; // Scalar outputs, one word each
  localparam logic [11:0] HCC_ARRAY_OFS   = 12'h100; // Argument array window base
  // Bit positions inside the control word
  localparam int HCC_GO_BIT       = 0;
  localparam int HCC_FINISHED_BIT = 1;
  localparam int HCC_QUIET_BIT    = 2;
  localparam int HCC_ACCEPTS_BIT  = 3;
  localparam int HCC_PROCEED_BIT  = 4;
  localparam int HCC_RESTART_BIT  = 7;
  // Interrupt source numbers
  localparam int HCC_SRC_FINISHED = 0;
  localparam int HCC_SRC_ACCEPTS  = 1;
  localparam int HCC_NUM_SRC      = 2;
  // Reset values
  localparam logic [31:0] HCC_WORD_RST = 32'h0000_0000;
  localparam logic [1:0]  HCC_SRC_RST  = 2'h0;
  // Array window address decode
  localparam int HCC_WIN_MSB = 11;
  localparam int HCC_WIN_LSB = 8;
  localparam logic [3:0] HCC_WIN_TAG = 4'h1;
endpackage
